// ---- core/iia_pkg.sv ----
// Summary of operation
// - selected input state, index 0..2, reads 1 when energised
// - packed input word, input zero in bit 0, values 0..7
// - each input counts pulses after a 15 ms debounce
// - counters span 0..65535 and wrap, host tracks overruns
// - pulse count read returns 16 bits and does not clear
// - rate meter only on input zero, selector 0, 100 to 15000 Hz
// - rate read returns latest measurement in whole hertz, 16 bits
// - analog channels sampled every 5 ms, mean of last four samples
// - analog result in millivolts, 0 to 3300
// - analog query picks channel 0 or 1 by index
`default_nettype none
package iia_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ          = 125000000;
  localparam int unsigned DEBOUNCE_MS     = 15;
  localparam int unsigned DEBOUNCE_CYC    = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int unsigned SAMPLE_MS       = 5;
  localparam int unsigned SAMPLE_CYC      = CLK_HZ / 1000 * SAMPLE_MS;
  localparam int unsigned GATE_MS         = 1000;
  localparam int unsigned GATE_CYC        = CLK_HZ / 1000 * GATE_MS;
  // ----------------------------------------
  // widths and scale
  // ----------------------------------------
  localparam int unsigned NUM_IN          = 3;
  localparam int unsigned NUM_AN          = 2;
  localparam int unsigned AVG_DEPTH       = 4;
  localparam int unsigned ADC_W           = 12;
  localparam logic [11:0] FULL_SCALE_MV   = 12'hce4;
  localparam logic [11:0] ADC_MAX         = 12'hfff;
  localparam logic [15:0] TALLY_RST       = 16'h0000;
  localparam logic [1:0]  RATE_CHAN       = 2'h0;
  typedef enum logic [1:0] {IIA_IDLE, IIA_REQ, IIA_WAIT} iia_adc_st_t;
endpackage
`default_nettype wire

// ---- core/iia_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module iia_top #(
  parameter int unsigned DEBOUNCE_CYC = iia_pkg::DEBOUNCE_CYC,
  parameter int unsigned SAMPLE_CYC   = iia_pkg::SAMPLE_CYC,
  parameter int unsigned GATE_CYC     = iia_pkg::GATE_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        isolated_input_a,
  input  wire logic        isolated_input_b,
  input  wire logic        isolated_input_c,
  input  wire logic [1:0]  input_index,
  input  wire logic [1:0]  rate_channel_select,
  input  wire logic        analog_index,
  output logic             read_single_input_state,
  output logic [2:0]       read_packed_input_state,
  output logic [15:0]      read_pulse_tally,
  output logic [15:0]      read_measured_rate,
  output logic [11:0]      read_averaged_voltage,
  output logic             adc_req,
  output logic             adc_chan,
  input  wire logic        adc_valid,
  input  wire logic [11:0] adc_data
);
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) rst_sync_q <= 2'h0;
    else       rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------
  // per-input conditioning
  // ----------------------------------------
  // one copy per pin keeps the three paths identical
  logic [2:0]  live_q;
  logic [15:0] tally_q [3];
  iia_in_chan #(
    .DEBOUNCE_CYC (DEBOUNCE_CYC)
  ) u_in_a (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pin   (isolated_input_a),
    .live  (live_q[0]),
    .tally (tally_q[0])
  );
  iia_in_chan #(
    .DEBOUNCE_CYC (DEBOUNCE_CYC)
  ) u_in_b (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pin   (isolated_input_b),
    .live  (live_q[1]),
    .tally (tally_q[1])
  );
  iia_in_chan #(
    .DEBOUNCE_CYC (DEBOUNCE_CYC)
  ) u_in_c (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pin   (isolated_input_c),
    .live  (live_q[2]),
    .tally (tally_q[2])
  );

  // ----------------------------------------
  // rate meter on input zero
  // ----------------------------------------
  // one second gate gives whole hertz directly; 6/32 us phases are far
  // above the sample period so no edge is missed
  logic        prev0_q, prev0_d;
  logic [26:0] gate_q, gate_d;
  logic [16:0] edges_q, edges_d;
  logic [15:0] rate_q, rate_d;
  always_comb begin
    prev0_d = live_q[0];
    gate_d = gate_q + 27'h0000001;
    edges_d = edges_q;
    rate_d = rate_q;
    if (live_q[0] && !prev0_q && edges_q != 17'h1ffff) edges_d = edges_q + 17'h00001;
    if (gate_q >= 27'(GATE_CYC - 1)) begin
      gate_d = 27'h0000000;
      // an edge on the closing cycle opens the next window instead of being lost
      edges_d = (live_q[0] && !prev0_q) ? 17'h00001 : 17'h00000;
      // saturate at the top of the 16-bit field
      rate_d = edges_q[16] ? 16'hffff : edges_q[15:0];
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prev0_q <= 1'b0;
      gate_q <= 27'h0000000;
      edges_q <= 17'h00000;
      rate_q <= 16'h0000;
    end else begin
      prev0_q <= prev0_d;
      gate_q <= gate_d;
      edges_q <= edges_d;
      rate_q <= rate_d;
    end
  end

  // ----------------------------------------
  // analog sampling and averaging
  // ----------------------------------------
  iia_pkg::iia_adc_st_t st_q, st_d;
  logic [19:0] tick_q, tick_d;
  logic        ch_q, ch_d;
  logic [11:0] smp_q [2][4];
  logic [11:0] smp_d [2][4];
  logic [11:0] avg_q [2];
  logic [11:0] avg_d [2];
  logic [13:0] sum;
  logic [25:0] prod;
  always_comb begin
    st_d = st_q;
    tick_d = tick_q + 20'h00001;
    ch_d = ch_q;
    smp_d = smp_q;
    avg_d = avg_q;
    sum = 14'h0000;
    prod = 26'h0000000;
    if (tick_q >= 20'(SAMPLE_CYC - 1)) tick_d = 20'h00000;
    case (st_q)
      iia_pkg::IIA_IDLE: begin
        if (tick_q >= 20'(SAMPLE_CYC - 1)) begin
          st_d = iia_pkg::IIA_REQ;
          ch_d = 1'b0;
        end
      end
      iia_pkg::IIA_REQ: st_d = iia_pkg::IIA_WAIT;
      iia_pkg::IIA_WAIT: begin
        if (adc_valid) begin
          smp_d[ch_q][3] = smp_q[ch_q][2];
          smp_d[ch_q][2] = smp_q[ch_q][1];
          smp_d[ch_q][1] = smp_q[ch_q][0];
          smp_d[ch_q][0] = adc_data;
          sum = 14'(adc_data) + 14'(smp_q[ch_q][0]) + 14'(smp_q[ch_q][1])
              + 14'(smp_q[ch_q][2]);
          // scale mean of raw codes to millivolts
          prod = 26'(sum[13:2]) * 26'(iia_pkg::FULL_SCALE_MV);
          avg_d[ch_q] = 12'(prod / 26'(iia_pkg::ADC_MAX));
          if (ch_q) st_d = iia_pkg::IIA_IDLE;
          else begin
            ch_d = 1'b1;
            st_d = iia_pkg::IIA_REQ;
          end
        end
      end
      default: st_d = iia_pkg::IIA_IDLE;
    endcase
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= iia_pkg::IIA_IDLE;
      tick_q <= 20'h00000;
      ch_q <= 1'b0;
      for (int c = 0; c < 2; c++) begin
        avg_q[c] <= 12'h000;
        for (int k = 0; k < 4; k++) smp_q[c][k] <= 12'h000;
      end
    end else begin
      st_q <= st_d;
      tick_q <= tick_d;
      ch_q <= ch_d;
      smp_q <= smp_d;
      avg_q <= avg_d;
    end
  end
  assign adc_req = (st_q == iia_pkg::IIA_REQ);
  assign adc_chan = ch_q;

  // ----------------------------------------
  // query answers
  // ----------------------------------------
  logic        one_d;
  logic [2:0]  pack_d;
  logic [15:0] tal_d, rt_d;
  logic [11:0] av_d;
  always_comb begin
    pack_d = live_q;
    case (input_index)
      2'h0: begin
        one_d = live_q[0];
        tal_d = tally_q[0];
      end
      2'h1: begin
        one_d = live_q[1];
        tal_d = tally_q[1];
      end
      2'h2: begin
        one_d = live_q[2];
        tal_d = tally_q[2];
      end
      // index three names no input
      default: begin
        one_d = 1'b0;
        tal_d = 16'h0000;
      end
    endcase
    rt_d = (rate_channel_select == iia_pkg::RATE_CHAN) ? rate_q : 16'h0000;
    av_d = avg_q[analog_index];
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      read_single_input_state <= 1'b0;
      read_packed_input_state <= 3'h0;
      read_pulse_tally <= 16'h0000;
      read_measured_rate <= 16'h0000;
      read_averaged_voltage <= 12'h000;
    end else begin
      read_single_input_state <= one_d;
      read_packed_input_state <= pack_d;
      read_pulse_tally <= tal_d;
      read_measured_rate <= rt_d;
      read_averaged_voltage <= av_d;
    end
  end
endmodule

// ----------------------------------------
// one isolated input: synchroniser, debounce, tally
// ----------------------------------------
module iia_in_chan #(
  parameter int unsigned DEBOUNCE_CYC = iia_pkg::DEBOUNCE_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        pin,
  output logic             live,
  output logic [15:0]      tally
);
  // ----------------------------------------
  // synchroniser
  // ----------------------------------------
  // three stages; a level counts once stages two and three agree
  logic        s1_q;
  logic        s2_q;
  logic        s3_q;
  logic        live_q;
  logic        s1_d;
  logic        s2_d;
  logic        s3_d;
  logic        live_d;
  always_comb begin
    s1_d   = pin;
    s2_d   = s1_q;
    s3_d   = s2_q;
    live_d = live_q;
    if (s2_q == s3_q) live_d = s3_q;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      s3_q   <= 1'b0;
      live_q <= 1'b0;
    end else begin
      s1_q   <= s1_d;
      s2_q   <= s2_d;
      s3_q   <= s3_d;
      live_q <= live_d;
    end
  end
  assign live = live_q;

  // ----------------------------------------
  // debounce and tally
  // ----------------------------------------
  // a level must hold the whole window before it is believed
  logic        db_q;
  logic        db_d;
  logic [23:0] dbc_q;
  logic [23:0] dbc_d;
  logic [15:0] tally_q;
  logic [15:0] tally_d;
  always_comb begin
    db_d    = db_q;
    dbc_d   = dbc_q;
    tally_d = tally_q;
    if (live_q == db_q) begin
      dbc_d = 24'h000000;
    end else if (dbc_q >= 24'(DEBOUNCE_CYC - 1)) begin
      dbc_d = 24'h000000;
      db_d  = live_q;
      // count rising edges; wraps without carry, the host keeps overruns
      if (live_q) tally_d = tally_q + 16'h0001;
    end else begin
      dbc_d = dbc_q + 24'h000001;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      db_q    <= 1'b0;
      dbc_q   <= 24'h000000;
      tally_q <= iia_pkg::TALLY_RST;
    end else begin
      db_q    <= db_d;
      dbc_q   <= dbc_d;
      tally_q <= tally_d;
    end
  end
  assign tally = tally_q;
endmodule
`default_nettype wire

// ---- verif/iia_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module iia_monitor (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic [1:0]  input_index,
  input wire logic [1:0]  rate_channel_select,
  input wire logic        analog_index,
  input wire logic        read_single_input_state,
  input wire logic [2:0]  read_packed_input_state,
  input wire logic [15:0] read_pulse_tally,
  input wire logic [15:0] read_measured_rate,
  input wire logic [11:0] read_averaged_voltage,
  input wire logic        adc_req,
  input wire logic        adc_chan,
  input wire logic        adc_valid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ----
  // port relations
  // ----
  idx_three_a: assert property (input_index == 2'h3 |=> !read_single_input_state)
    else $error("index three not zero");
  single_packed_a: assert property ($past(input_index) == 2'h2 &&
    $stable(read_packed_input_state) |-> read_single_input_state == read_packed_input_state[2])
    else $error("single and packed differ");
  rate_sel_a: assert property (rate_channel_select != 2'h0 |=> read_measured_rate == 16'h0)
    else $error("rate not zero off channel");
  tally_step_a: assert property ($changed(read_pulse_tally) &&
    $past(input_index) == $past(input_index, 2) |->
    read_pulse_tally == $past(read_pulse_tally) + 16'h1)
    else $error("tally moved by other than one");
  mv_range_a: assert property (read_averaged_voltage <= 12'hce4)
    else $error("voltage above full scale");
  volt_cause_a: assert property ($changed(read_averaged_voltage) &&
    $past(analog_index) == $past(analog_index, 2) |-> $past(adc_valid) ||
    $past(adc_valid, 2) || $past(adc_valid, 3) || $past(adc_valid, 4))
    else $error("voltage moved without sample");
  req_pulse_a: assert property (adc_req |=> !adc_req)
    else $error("sample request too long");
  chan_order_a: assert property (adc_req && !adc_chan |-> ##[2:12] adc_req && adc_chan)
    else $error("second channel not sampled");
endmodule
bind iia_top iia_monitor mon (.mclk, .rstn, .input_index, .rate_channel_select,
  .analog_index, .read_single_input_state, .read_packed_input_state, .read_pulse_tally,
  .read_measured_rate, .read_averaged_voltage, .adc_req, .adc_chan, .adc_valid);
`default_nettype wire

// ---- verif/iia_field.sv ----
`timescale 1ns/1ps
`default_nettype none
module iia_field (
  input  wire logic        mclk,
  input  wire logic        adc_req,
  input  wire logic        adc_chan,
  input  wire logic        slow,
  input  wire logic [11:0] code_a,
  input  wire logic [11:0] code_b,
  input  wire logic [11:0] spread,
  output var logic         adc_valid,
  output var logic [11:0]  adc_data
);
  logic [2:0] wait_q = 3'h0;
  logic       ch_q = 1'b0;
  logic [1:0] flip_q = 2'h0;
  initial adc_data = 12'h0;
  always @(posedge mclk) begin
    adc_valid <= 1'b0;
    // idle bus toggles so a stale code is never mistaken for a sample
    adc_data <= ~adc_data;
    if (adc_req) begin
      ch_q <= adc_chan;
      wait_q <= slow ? 3'h4 : 3'h1;
    end else if (wait_q == 3'h1) begin
      adc_valid <= 1'b1;
      // alternate above and below the code; any four in a row average back to it
      adc_data <= (ch_q ? code_b : code_a) + (flip_q[ch_q] ? spread : -spread);
      flip_q[ch_q] <= ~flip_q[ch_q];
    end
    if (!adc_req && wait_q != 3'h0) wait_q <= wait_q - 3'h1;
  end
endmodule
`default_nettype wire

// ---- verif/isolated_input_acquisition_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module isolated_input_acquisition_tb;
  logic        mclk, rstn, single, aidx, slow, req, ch, vld;
  logic [2:0]  pins, packed_s;
  logic [1:0]  idx, rsel;
  logic [11:0] code_a, code_b, adata, volt, spread;
  logic [15:0] tally, rate;
  logic [31:0] seed;
  int          bad_count, total_checks, i, j;
  iia_top #(.DEBOUNCE_CYC(20), .SAMPLE_CYC(50), .GATE_CYC(1000)) dut (.mclk(mclk),
    .rstn(rstn), .isolated_input_a(pins[0]), .isolated_input_b(pins[1]),
    .isolated_input_c(pins[2]), .input_index(idx), .rate_channel_select(rsel),
    .analog_index(aidx), .read_single_input_state(single), .read_packed_input_state(packed_s),
    .read_pulse_tally(tally), .read_measured_rate(rate), .read_averaged_voltage(volt),
    .adc_req(req), .adc_chan(ch), .adc_valid(vld), .adc_data(adata));
  iia_field far (.mclk(mclk), .adc_req(req), .adc_chan(ch), .slow(slow), .code_a(code_a),
    .code_b(code_b), .spread(spread), .adc_valid(vld), .adc_data(adata));
  // ----
  // helpers
  // ----
  function automatic logic [31:0] nxt(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [11:0] to_mv(input logic [11:0] c);
    return 12'((32'(c) * 32'hce4) / 32'hfff);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pulse(input int k, input int w);
    pins[k] = 1'b1;
    tick(w);
    pins[k] = 1'b0;
    tick(w);
  endtask
  task automatic complete_run();
    $display("checks=%0d errors=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    repeat (100000) @(posedge mclk);
    bad_count++;
    complete_run();
  end
  initial begin
    {rstn, pins, idx, rsel, aidx, slow, code_a, code_b, spread} = '0;
    seed = 32'h6d23;
    tick(20);
    rstn = 1'b1;
    for (i = 0; i < 6; i++) begin
      seed = nxt(seed);
      pins = seed[2:0];
      tick(8);
      chk(16'(packed_s), 16'(pins));
      for (j = 0; j < 4; j++) begin
        idx = 2'(j);
        tick(2);
        chk(16'(single), j < 3 ? 16'(pins[j]) : 16'h0);
      end
    end
    // second reset so every tally starts from zero
    pins = 3'h0;
    rstn = 1'b0;
    tick(20);
    rstn = 1'b1;
    tick(4);
    // keep one tally in view so the step check sees it count
    idx = 2'h2;
    for (j = 0; j < 3; j++) begin
      pulse(j, 10);
      for (i = 0; i <= j; i++) pulse(j, 25 + 5 * i);
    end
    for (j = 0; j < 3; j++) begin
      idx = 2'(j);
      tick(2);
      chk(tally, 16'(j + 1));
      tick(2);
      chk(tally, 16'(j + 1));
    end
    idx = 2'h0;
    for (i = 0; i < 250; i++) begin
      pulse(0, 5);
      if (i == 240) chk(rate, 16'h64);
    end
    rsel = 2'h1;
    tick(2);
    chk(rate, 16'h0);
    rsel = 2'h0;
    for (i = 0; i < 3; i++) begin
      seed = nxt(seed);
      // codes stay one spread clear of both rails so the dither never wraps
      spread = i == 0 ? 12'h000 : 12'h040;
      code_a = i == 0 ? 12'h0 : 12'h040 + seed[11:0] % 12'hf80;
      code_b = i == 0 ? 12'hfff : 12'h040 + seed[23:12] % 12'hf80;
      slow = seed[24];
      tick(400);
      for (j = 0; j < 2; j++) begin
        aidx = j[0];
        tick(2);
        chk(16'(volt), 16'(to_mv(j == 0 ? code_a : code_b)));
      end
    end
    complete_run();
  end
endmodule
`default_nettype wire
